// *** rtl/fcj_pkg.sv ***
// Package: constants for the fastening count judge
package fcj_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_NS         = 20;
   // Fixed batch-OK hold after a corrected NOK
   localparam int unsigned CORR_OK_MS     = 1000;
   localparam int unsigned CORR_OK_CYC    = CORR_OK_MS * (CLK_HZ / 1000);
   // Buzzer pulse on and gap time
   localparam int unsigned BUZ_MS         = 100;
   localparam int unsigned BUZ_CYC        = BUZ_MS * (CLK_HZ / 1000);
   // Millisecond tick for the line, start-torque and cycle-over timers
   localparam int unsigned MS_CYC         = CLK_HZ / 1000;

   localparam logic [2:0]  LCM_TIMER      = 3'h3;
   localparam logic [2:0]  LCM_WORK       = 3'h4;
   localparam logic [3:0]  TM_PULSE_A     = 4'h3;
   localparam logic [3:0]  TM_PULSE_B     = 4'h5;

   localparam logic [13:0] PULSE_LO_RST   = 14'h0002;
   localparam logic [13:0] PULSE_HI_RST   = 14'h0064;
   localparam logic [13:0] PULSE_LO_MAX   = 14'h270e;
   localparam logic [13:0] PULSE_HI_MAX   = 14'h270f;
   localparam logic [2:0]  EXTRA_RST      = 3'h1;
   localparam logic [2:0]  EXTRA_MAX      = 3'h5;
   localparam int unsigned NWORK          = 8;
   localparam int unsigned NSEL           = 5;

   typedef enum logic [1:0] {
      B_IDLE = 2'b00,
      B_RUN  = 2'b01,
      B_OK   = 2'b11,
      B_NOK  = 2'b10
   } batch_st_t;
endpackage : fcj_pkg

// *** rtl/fcj_preset_mem.sv ***
// Per-work preset memory: batch count and batch-OK duration
`timescale 1ns/1ps
module fcj_preset_mem (
   input  wire logic        i_clk,
   input  wire logic        i_we,
   input  wire logic [2:0]  i_waddr,
   input  wire logic [23:0] i_wdata,
   input  wire logic [2:0]  i_raddr,
   output logic      [23:0] o_rdata
);
   logic [23:0] mem_q [fcj_pkg::NWORK];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
   end
endmodule : fcj_preset_mem

// *** rtl/fastening_count_judge.sv ***
// Fastening count judge: batch counting, cycle errors, pulse checks
// Notes on behaviour
// - Method 3 timer starts on first judgment or wrench signal
// - Method 3 batch OK; rearm after OK drops
// - Method 3 timer expiry means batch NOK
// - Method 3 forces batch-OK duration zero
// - Method 4 one-hot work input arms work
// - Method 4 per-work OK output, per-work duration
// - Method 4 corrected NOK gives one second OK
// - Work input drop clears batch OK
// - Method 4 early work input drop means batch NOK
// - Buzzer one pulse per OK, two at count-up
// - Start torque too early flags error
// - Start-torque error holds fail and buzzer
// - Errors clear on reset input or restart
// - Cycle-over timer flags unfinished fastening
// - Acknowledge silences buzzer, error stays
// - Measure start-to-torque time
// - Pulse count below low limit is NOK
// - Pulse count above high limit stops tool
// - Pulse limits only in methods 3, 5
// - Post-cut option selects peak torque source
// - Extra pulses after cut, then valve stops
// - Work scheme: binary eight or one-hot five
`timescale 1ns/1ps
module fastening_count_judge (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // Configuration (static)
   input  wire logic [2:0]  i_line_count_method,
   input  wire logic        i_work_select_scheme,
   input  wire logic [3:0]  i_tightening_method,
   input  wire logic        i_buzzer_confirm,
   input  wire logic        i_start_torque_check,
   input  wire logic        i_cycle_over_check,
   input  wire logic        i_restart_clears,
   input  wire logic        i_post_cut_measure_select,
   input  wire logic [2:0]  i_post_cut_extra_pulses,
   input  wire logic [13:0] i_pulse_low_limit,
   input  wire logic [13:0] i_pulse_high_limit,
   input  wire logic [15:0] i_line_timer_ms,
   input  wire logic [15:0] i_start_err_ms,
   input  wire logic [15:0] i_cycle_over_ms,
   // Per-work presets
   input  wire logic        i_preset_we,
   input  wire logic [2:0]  i_preset_work,
   input  wire logic [7:0]  i_preset_count,
   input  wire logic [15:0] i_preset_ok_ms,
   // Line controller pins
   input  wire logic [4:0]  i_work_sel,
   input  wire logic        i_pass,
   input  wire logic        i_error_clear,
   input  wire logic        i_ext_start,
   input  wire logic        i_wrench_signal,
   // Panel strobes (same clock)
   input  wire logic        i_panel_reset,
   input  wire logic        i_panel_ack,
   // Tool
   input  wire logic        i_tool_pulse,
   input  wire logic        i_at_start_torque,
   input  wire logic        i_at_cut_torque,
   input  wire logic [11:0] i_torque,
   // Outputs
   output logic             o_valve_stop,
   output logic             o_fastening_fail_out,
   output logic             o_fastening_ok,
   output logic [7:0]       o_batch_ok,
   output logic             o_batch_incomplete_flag,
   output logic             o_buzzer,
   output logic             o_start_torque_err,
   output logic             o_cycle_over_err,
   output logic             o_pulse_low_nok,
   output logic             o_pulse_high_nok,
   output logic [15:0]      o_start_to_torque_time,
   output logic [11:0]      o_peak_torque,
   output logic [13:0]      o_pulse_total,
   output logic             o_work_invalid
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int unsigned NPIN = 12;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_q;
   logic [NPIN-1:0] pin_prev_q;
   logic [11:0]     torque_s1_q;
   logic [11:0]     torque_q;
   assign pin_raw = {i_work_sel, i_pass, i_error_clear, i_ext_start, i_wrench_signal,
                     i_tool_pulse, i_at_start_torque, i_at_cut_torque};
   always_ff @(posedge i_clk) begin
      pin_s1_q   <= pin_raw;
      pin_q      <= pin_s1_q;
      pin_prev_q <= pin_q;
      // Torque word assumed to move slowly against the clock
      torque_s1_q <= i_torque;
      torque_q    <= torque_s1_q;
   end
   logic [4:0] wsel;
   logic       pass_rise, clr_rise, start_rise, wrench_rise, pulse_rise;
   logic       st_trq, cut_trq, st_rise, cut_rise;
   assign wsel        = pin_q[11:7];
   assign pass_rise   = pin_q[6] & ~pin_prev_q[6];
   assign clr_rise    = pin_q[5] & ~pin_prev_q[5];
   assign start_rise  = pin_q[4] & ~pin_prev_q[4];
   assign wrench_rise = pin_q[3] & ~pin_prev_q[3];
   assign pulse_rise  = pin_q[2] & ~pin_prev_q[2];
   assign st_trq      = pin_q[1];
   assign cut_trq     = pin_q[0];
   assign st_rise     = pin_q[1] & ~pin_prev_q[1];
   assign cut_rise    = pin_q[0] & ~pin_prev_q[0];

   // ----------------------------------------------------------------
   // Work decode and presets
   // ----------------------------------------------------------------
   logic [2:0] work_idx;
   logic       one_hot_ok;
   logic [2:0] onehot_cnt;
   always_comb begin
      onehot_cnt = 3'h0;
      work_idx   = 3'h0;
      for (int i = 0; i < 5; i++) begin
         onehot_cnt = onehot_cnt + {2'h0, wsel[i]};
         if (wsel[i]) begin
            work_idx = 3'(i);
         end
      end
      if (!i_work_select_scheme) begin
         work_idx = wsel[2:0];
      end
   end
   assign one_hot_ok = (onehot_cnt == 3'h1);

   logic [23:0] preset;
   fcj_preset_mem u_mem (
      .i_clk   (i_clk),
      .i_we    (i_preset_we),
      .i_waddr (i_preset_work),
      .i_wdata ({i_preset_count, i_preset_ok_ms}),
      .i_raddr (work_idx),
      .o_rdata (preset)
   );

   // ----------------------------------------------------------------
   // Millisecond tick
   // ----------------------------------------------------------------
   logic [15:0] tick_cnt_q;
   logic        ms_tick;
   assign ms_tick = (tick_cnt_q == 16'(fcj_pkg::MS_CYC - 1));
   always_ff @(posedge i_clk) begin
      if (i_srst || ms_tick) tick_cnt_q <= 16'h0;
      else                   tick_cnt_q <= tick_cnt_q + 16'h1;
   end

   // ----------------------------------------------------------------
   // Fastening cycle: pulses, extra pulses, peak
   // ----------------------------------------------------------------
   logic        pulse_mode, in_cycle_q, after_cut_q, judge_q, ok_fast;
   logic [13:0] pulses_q;
   logic [2:0]  extra_q, extra_set;
   logic        err_clear;
   assign pulse_mode = (i_tightening_method == fcj_pkg::TM_PULSE_A) ||
                       (i_tightening_method == fcj_pkg::TM_PULSE_B);
   assign extra_set  = (i_post_cut_extra_pulses == 3'h0) ? 3'h1 :
                       (i_post_cut_extra_pulses > fcj_pkg::EXTRA_MAX) ? fcj_pkg::EXTRA_MAX
                       : i_post_cut_extra_pulses;
   logic pulse_hi;
   assign pulse_hi = pulse_mode && in_cycle_q && !after_cut_q &&
                     (pulses_q > i_pulse_high_limit);

   always_ff @(posedge i_clk) begin
      judge_q <= 1'b0;
      if (i_srst) begin
         in_cycle_q   <= 1'b0;
         after_cut_q  <= 1'b0;
         pulses_q     <= 14'h0;
         extra_q      <= 3'h0;
         o_valve_stop <= 1'b0;
         o_peak_torque <= 12'h0;
         o_pulse_total <= 14'h0;
         o_pulse_low_nok  <= 1'b0;
         o_pulse_high_nok <= 1'b0;
      end else begin
         if (err_clear) begin
            o_valve_stop     <= 1'b0;
            o_pulse_low_nok  <= 1'b0;
            o_pulse_high_nok <= 1'b0;
         end
         if (st_rise && !in_cycle_q) begin
            in_cycle_q    <= 1'b1;
            after_cut_q   <= 1'b0;
            pulses_q      <= 14'h0;
            o_peak_torque <= 12'h0;
            o_valve_stop  <= 1'b0;
         end else if (in_cycle_q) begin
            // Option 1 freezes peak at the cut level
            if ((!after_cut_q || !i_post_cut_measure_select) &&
                torque_q > o_peak_torque) begin
               o_peak_torque <= torque_q;
            end
            if (pulse_rise && !after_cut_q && pulses_q != 14'h3fff) begin
               pulses_q <= pulses_q + 14'h1;
            end
            if (pulse_hi) begin
               o_pulse_high_nok <= 1'b1;
               o_valve_stop     <= 1'b1;
               in_cycle_q       <= 1'b0;
               o_pulse_total    <= pulses_q;
            end else if (cut_rise && !after_cut_q) begin
               after_cut_q <= 1'b1;
               extra_q     <= 3'h0;
               o_pulse_total <= pulses_q;
               if (pulse_mode && pulses_q < i_pulse_low_limit) begin
                  o_pulse_low_nok <= 1'b1;
               end
            end else if (after_cut_q && pulse_rise) begin
               if (!pulse_mode || extra_q + 3'h1 >= extra_set) begin
                  o_valve_stop <= 1'b1;
                  in_cycle_q   <= 1'b0;
                  judge_q      <= 1'b1;
               end else begin
                  extra_q <= extra_q + 3'h1;
               end
            end
         end
      end
   end
   assign ok_fast = judge_q && !o_pulse_low_nok && !o_fastening_fail_out;

   // ----------------------------------------------------------------
   // Start torque and cycle-over errors
   // ----------------------------------------------------------------
   logic        timing_q;
   logic [15:0] tss_q, cyc_q;
   assign err_clear = clr_rise || i_panel_reset ||
                      (i_restart_clears && start_rise);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         timing_q <= 1'b0;
         tss_q    <= 16'h0;
         cyc_q    <= 16'h0;
         o_start_torque_err     <= 1'b0;
         o_cycle_over_err       <= 1'b0;
         o_start_to_torque_time <= 16'h0;
      end else begin
         if (err_clear) begin
            o_start_torque_err <= 1'b0;
            o_cycle_over_err   <= 1'b0;
         end
         if (start_rise) begin
            timing_q <= 1'b1;
            tss_q    <= 16'h0;
            cyc_q    <= 16'h0;
         end else if (timing_q) begin
            if (ms_tick && tss_q != 16'hffff) tss_q <= tss_q + 16'h1;
            if (ms_tick && cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h1;
            if (st_rise) begin
               o_start_to_torque_time <= tss_q;
               if (i_start_torque_check && tss_q < i_start_err_ms) begin
                  o_start_torque_err <= 1'b1;
               end
            end
            if (judge_q) begin
               timing_q <= 1'b0;
            end else if (i_cycle_over_check && cyc_q >= i_cycle_over_ms) begin
               o_cycle_over_err <= 1'b1;
               timing_q         <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) o_fastening_fail_out <= 1'b0;
      else o_fastening_fail_out <= o_start_torque_err || o_cycle_over_err ||
                                   o_pulse_high_nok || o_pulse_low_nok;
   end

   // ----------------------------------------------------------------
   // Batch control
   // ----------------------------------------------------------------
   fcj_pkg::batch_st_t st_q;
   logic [7:0]  left_q;
   logic [2:0]  work_q;
   logic [15:0] ok_ms_q;
   logic [31:0] ok_cyc_q;
   logic        corr_q, count_up;
   logic        m3, m4;
   assign m3 = (i_line_count_method == fcj_pkg::LCM_TIMER);
   assign m4 = (i_line_count_method == fcj_pkg::LCM_WORK);
   assign count_up = ok_fast && left_q == 8'h1;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= fcj_pkg::B_IDLE;
         left_q <= 8'h0;
         work_q <= 3'h0;
         ok_ms_q <= 16'h0;
         ok_cyc_q <= 32'h0;
         corr_q <= 1'b0;
         o_batch_ok <= 8'h0;
         o_batch_incomplete_flag <= 1'b0;
         o_work_invalid <= 1'b0;
      end else begin
         o_work_invalid <= m4 && i_work_select_scheme && |wsel && !one_hot_ok;
         case (st_q)
            fcj_pkg::B_IDLE: begin
               o_batch_ok <= 8'h0;
               if (m3 && (judge_q || wrench_rise)) begin
                  st_q    <= fcj_pkg::B_RUN;
                  left_q  <= preset[23:16] - {7'h0, ok_fast};
                  ok_ms_q <= 16'h0;
                  // A one-piece batch is complete at its first OK judgment
                  if (ok_fast && preset[23:16] == 8'h1) begin
                     st_q               <= fcj_pkg::B_OK;
                     o_batch_ok[work_q] <= 1'b1;
                  end
               // Selection must stand one cycle so the preset read catches up
               end else if (m4 && i_work_select_scheme && one_hot_ok &&
                            wsel == pin_prev_q[11:7]) begin
                  st_q    <= fcj_pkg::B_RUN;
                  work_q  <= work_idx;
                  left_q  <= preset[23:16];
                  ok_ms_q <= preset[15:0];
               end
               o_batch_incomplete_flag <= 1'b0;
               corr_q <= 1'b0;
            end
            fcj_pkg::B_RUN: begin
               if (ok_fast) left_q <= left_q - 8'h1;
               if (count_up) begin
                  st_q <= fcj_pkg::B_OK;
                  o_batch_ok[work_q] <= 1'b1;
                  ok_cyc_q <= 32'h0;
               end else if (m3 && ms_tick && ok_ms_q >= i_line_timer_ms) begin
                  st_q <= fcj_pkg::B_NOK;
                  o_batch_incomplete_flag <= 1'b1;
               end else if (m4 && !wsel[work_q]) begin
                  st_q <= fcj_pkg::B_NOK;
                  o_batch_incomplete_flag <= 1'b1;
               end
               if (m3 && ms_tick) ok_ms_q <= ok_ms_q + 16'h1;
            end
            fcj_pkg::B_OK: begin
               ok_cyc_q <= ok_cyc_q + 32'h1;
               // Method 3 duration forced to zero: OK lasts one cycle
               if (m3) begin
                  o_batch_ok <= 8'h0;
                  if (o_batch_ok == 8'h0) st_q <= fcj_pkg::B_IDLE;
               end else if (corr_q) begin
                  if (ok_cyc_q >= 32'(fcj_pkg::CORR_OK_CYC - 1) || !wsel[work_q]) begin
                     o_batch_ok <= 8'h0;
                     st_q <= fcj_pkg::B_IDLE;
                  end
               end else if (!wsel[work_q] ||
                            (ok_ms_q != 16'h0 && ok_cyc_q >=
                             32'(ok_ms_q) * 32'(fcj_pkg::MS_CYC))) begin
                  o_batch_ok <= 8'h0;
                  st_q <= fcj_pkg::B_IDLE;
               end
            end
            fcj_pkg::B_NOK: begin
               if (ok_fast && left_q != 8'h0) left_q <= left_q - 8'h1;
               if (m4 && (pass_rise || count_up)) begin
                  st_q <= fcj_pkg::B_OK;
                  corr_q <= 1'b1;
                  ok_cyc_q <= 32'h0;
                  o_batch_ok[work_q] <= 1'b1;
                  o_batch_incomplete_flag <= 1'b0;
               end else if (m3 && (pass_rise || count_up)) begin
                  st_q <= fcj_pkg::B_IDLE;
                  o_batch_incomplete_flag <= 1'b0;
               end
            end
            default: st_q <= fcj_pkg::B_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Buzzer
   // ----------------------------------------------------------------
   logic [2:0]  buz_ph_q;
   logic [23:0] buz_cnt_q;
   logic        err_buz_q;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         buz_ph_q  <= 3'h0;
         buz_cnt_q <= 24'h0;
         err_buz_q <= 1'b0;
         o_buzzer  <= 1'b0;
         o_fastening_ok <= 1'b0;
      end else begin
         o_fastening_ok <= ok_fast;
         if (err_clear || i_panel_ack) err_buz_q <= 1'b0;
         else if ((timing_q && st_rise && i_start_torque_check &&
                   tss_q < i_start_err_ms) || pulse_hi) err_buz_q <= 1'b1;
         else if (timing_q && i_cycle_over_check && cyc_q >= i_cycle_over_ms &&
                  !judge_q && !start_rise) err_buz_q <= 1'b1;
         if (ok_fast && i_buzzer_confirm) begin
            buz_ph_q  <= count_up ? 3'h3 : 3'h1;
            buz_cnt_q <= 24'h0;
         end else if (buz_ph_q != 3'h0) begin
            if (buz_cnt_q == 24'(fcj_pkg::BUZ_CYC - 1)) begin
               buz_cnt_q <= 24'h0;
               buz_ph_q  <= buz_ph_q - 3'h1;
            end else begin
               buz_cnt_q <= buz_cnt_q + 24'h1;
            end
         end
         o_buzzer <= err_buz_q || buz_ph_q[0];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_m3_ok_short;
      @(posedge i_clk) disable iff (i_srst)
      (m3 && o_batch_ok != 8'h0) |=> (o_batch_ok == 8'h0);
   endproperty
   a_m3_ok_short: assert property (p_m3_ok_short) else $error("Method 3 OK too long");

   property p_fail_follows;
      @(posedge i_clk) disable iff (i_srst)
      $rose(o_start_torque_err) |=> o_fastening_fail_out;
   endproperty
   a_fail_follows: assert property (p_fail_follows) else $error("Fail missing");

   property p_hi_stops;
      @(posedge i_clk) disable iff (i_srst)
      pulse_hi |=> (o_valve_stop && o_pulse_high_nok);
   endproperty
   a_hi_stops: assert property (p_hi_stops) else $error("High pulse not stopped");

   property p_no_pulse_nok;
      @(posedge i_clk) disable iff (i_srst)
      (!pulse_mode && !o_pulse_low_nok) |=> !$rose(o_pulse_low_nok);
   endproperty
   a_no_pulse_nok: assert property (p_no_pulse_nok) else $error("Pulse NOK off-mode");

   property p_clear;
      @(posedge i_clk) disable iff (i_srst)
      (i_panel_reset && !(timing_q && (st_rise || i_cycle_over_check)))
         |=> (!o_start_torque_err && !o_cycle_over_err);
   endproperty
   a_clear: assert property (p_clear) else $error("Error not cleared");

   property p_drop_nok;
      @(posedge i_clk) disable iff (i_srst)
      (st_q == fcj_pkg::B_RUN && m4 && !wsel[work_q] && !count_up)
         |=> o_batch_incomplete_flag;
   endproperty
   a_drop_nok: assert property (p_drop_nok) else $error("Missing batch NOK");

   property p_drop_ok;
      @(posedge i_clk) disable iff (i_srst)
      (st_q == fcj_pkg::B_OK && m4 && !wsel[work_q]) |=> (o_batch_ok == 8'h0);
   endproperty
   a_drop_ok: assert property (p_drop_ok) else $error("OK not dropped");

   property p_onehot_ok;
      @(posedge i_clk) disable iff (i_srst)
      $rose(o_batch_ok != 8'h0) |-> $onehot(o_batch_ok);
   endproperty
   a_onehot_ok: assert property (p_onehot_ok) else $error("Several OK outputs");
endmodule : fastening_count_judge

// *** verif/line_ctrl_model.sv ***
// Line controller model: holds a work-select mask, drops it once batch OK shows
`timescale 1ns/1ps
module line_ctrl_model (
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic [4:0] i_mask,
   input  wire logic [7:0] i_batch_ok,
   output logic      [4:0] o_work_sel
);
   logic dropped_q;
   // Any batch OK ends the selection; a cleared mask rearms the model
   always_ff @(posedge i_clk) begin
      if (i_srst || i_mask == 5'h00) begin
         dropped_q <= 1'b0;
      end else if (|i_batch_ok) begin
         dropped_q <= 1'b1;
      end
   end
   assign o_work_sel = dropped_q ? 5'h00 : i_mask;
endmodule : line_ctrl_model

// *** verif/fastening_count_judge_tb.sv ***
// Testbench for the fastening count judge
`timescale 1ns/1ps
module fastening_count_judge_tb;
   logic        i_clk, i_srst, i_work_select_scheme, i_buzzer_confirm, i_start_torque_check;
   logic        i_restart_clears, i_preset_we, i_pass, i_error_clear, i_ext_start;
   logic        i_tool_pulse, i_at_start_torque, i_at_cut_torque, i_cycle_over_check;
   logic        i_post_cut_measure_select, i_wrench_signal, i_panel_reset, i_panel_ack;
   logic [2:0]  i_line_count_method, i_preset_work, i_post_cut_extra_pulses;
   logic [3:0]  i_tightening_method;
   logic [13:0] i_pulse_low_limit, i_pulse_high_limit, o_pulse_total;
   logic [15:0] i_line_timer_ms, i_start_err_ms, i_cycle_over_ms, i_preset_ok_ms;
   logic [7:0]  i_preset_count, o_batch_ok;
   logic [11:0] i_torque;
   logic [4:0]  i_work_sel, sel_mask;
   logic        o_valve_stop, o_fastening_fail_out, o_batch_incomplete_flag, o_start_torque_err;
   logic        o_pulse_low_nok, o_pulse_high_nok, o_work_invalid, seen_ok;
   logic        o_buzzer, o_cycle_over_err;
   int          fail_count, check_count;

   fastening_count_judge dut (.i_clk(i_clk), .i_srst(i_srst),
      .i_line_count_method(i_line_count_method), .i_work_select_scheme(i_work_select_scheme),
      .i_tightening_method(i_tightening_method), .i_buzzer_confirm(i_buzzer_confirm),
      .i_start_torque_check(i_start_torque_check), .i_cycle_over_check(i_cycle_over_check),
      .i_restart_clears(i_restart_clears), .i_post_cut_measure_select(i_post_cut_measure_select),
      .i_post_cut_extra_pulses(i_post_cut_extra_pulses), .i_pulse_low_limit(i_pulse_low_limit),
      .i_pulse_high_limit(i_pulse_high_limit), .i_line_timer_ms(i_line_timer_ms),
      .i_start_err_ms(i_start_err_ms), .i_cycle_over_ms(i_cycle_over_ms),
      .i_preset_we(i_preset_we), .i_preset_work(i_preset_work), .i_preset_count(i_preset_count),
      .i_preset_ok_ms(i_preset_ok_ms), .i_work_sel(i_work_sel), .i_pass(i_pass),
      .i_error_clear(i_error_clear), .i_ext_start(i_ext_start), .i_wrench_signal(i_wrench_signal),
      .i_panel_reset(i_panel_reset), .i_panel_ack(i_panel_ack), .i_tool_pulse(i_tool_pulse),
      .i_at_start_torque(i_at_start_torque), .i_at_cut_torque(i_at_cut_torque),
      .i_torque(i_torque), .o_valve_stop(o_valve_stop),
      .o_fastening_fail_out(o_fastening_fail_out), .o_fastening_ok(), .o_batch_ok(o_batch_ok),
      .o_batch_incomplete_flag(o_batch_incomplete_flag), .o_buzzer(o_buzzer),
      .o_start_torque_err(o_start_torque_err), .o_cycle_over_err(o_cycle_over_err),
      .o_pulse_low_nok(o_pulse_low_nok), .o_pulse_high_nok(o_pulse_high_nok),
      .o_start_to_torque_time(), .o_peak_torque(), .o_pulse_total(o_pulse_total),
      .o_work_invalid(o_work_invalid));

   line_ctrl_model partner (.i_clk(i_clk), .i_srst(i_srst), .i_mask(sel_mask),
      .i_batch_ok(o_batch_ok), .o_work_sel(i_work_sel));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // Sticky flag, since the model drops the selection the cycle after OK shows
   always @(posedge i_clk) begin
      if (i_srst) seen_ok <= 1'b0;
      else if (|o_batch_ok) seen_ok <= 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic pulse;
      i_tool_pulse = 1'b1;
      tick(4);
      i_tool_pulse = 1'b0;
      tick(4);
   endtask : pulse

   // Start, start torque, n pulses, cut, then the extra pulses
   task automatic fasten(input int n);
      i_ext_start = 1'b1;
      tick(6);
      i_at_start_torque = 1'b1;
      tick(6);
      repeat (n) pulse();
      i_at_cut_torque = 1'b1;
      tick(6);
      pulse();
      // Outside pulse methods the first pulse after cut already stops the tool
      if (n <= i_pulse_high_limit) chk(o_valve_stop, 16'(i_tightening_method != 4'h3));
      pulse();
      tick(4);
      if (n <= i_pulse_high_limit) chk(o_valve_stop, 1);
      {i_ext_start, i_at_start_torque, i_at_cut_torque} = 3'h0;
      tick(8);
   endtask : fasten

   task automatic wrap_up;
      $display("Checks %0d, errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      {i_work_select_scheme, i_buzzer_confirm, i_start_torque_check, i_preset_we} = 4'h0;
      {i_pass, i_error_clear, i_ext_start, i_tool_pulse, i_at_start_torque} = 5'h00;
      {i_at_cut_torque, i_cycle_over_check, i_post_cut_measure_select, i_wrench_signal} = 4'h0;
      {i_panel_reset, i_panel_ack, sel_mask, i_line_count_method} = 10'h000;
      {i_preset_work, i_torque, i_line_timer_ms, i_cycle_over_ms, i_preset_ok_ms} = 63'h0;
      i_restart_clears = 1'b1;
      i_tightening_method = 4'h3;
      i_post_cut_extra_pulses = 3'h2;
      {i_pulse_low_limit, i_pulse_high_limit} = {14'h0002, 14'h0064};
      {i_start_err_ms, i_preset_count} = {16'h0001, 8'h01};
      {fail_count, check_count} = 0;
      i_srst = 1'b1;
      tick(5);
      i_srst = 1'b0;
      tick(3);
      chk(o_batch_ok, 0);
      i_preset_we = 1'b1;
      for (int w = 0; w < 8; w++) begin
         i_preset_work = w[2:0];
         tick(1);
      end
      i_preset_we = 1'b0;
      fasten(3);
      chk(o_pulse_total, 3);
      chk(o_pulse_low_nok, 0);
      fasten(1);
      chk(o_pulse_low_nok, 1);
      i_pulse_high_limit = 14'h0005;
      fasten(6);
      chk({o_pulse_high_nok, o_valve_stop, o_fastening_fail_out}, 3'h7);
      i_tightening_method = 4'h1;
      fasten(1);
      chk({o_pulse_low_nok, o_pulse_high_nok}, 0);
      i_tightening_method = 4'h3;
      i_start_torque_check = 1'b1;
      fasten(3);
      chk({o_start_torque_err, o_fastening_fail_out, o_buzzer}, 3'h7);
      i_panel_reset = 1'b1;
      tick(1);
      i_panel_reset = 1'b0;
      tick(4);
      chk({o_start_torque_err, o_buzzer}, 0);
      // Zero cycle-over time: the error shows right after start
      {i_start_torque_check, i_cycle_over_check, i_ext_start} = 3'h3;
      tick(6);
      chk({o_cycle_over_err, o_fastening_fail_out, o_buzzer}, 3'h7);
      {i_cycle_over_check, i_ext_start, i_panel_ack} = 3'h1;
      tick(1);
      i_panel_ack = 1'b0;
      tick(3);
      chk({o_cycle_over_err, o_buzzer}, 2'h2);
      {i_line_count_method, i_work_select_scheme} = 4'h9;
      sel_mask = 5'h01;
      tick(8);
      fasten(3);
      chk({seen_ok, o_batch_ok}, 9'h100);
      sel_mask = 5'h00;
      tick(4);
      sel_mask = 5'h01;
      tick(8);
      sel_mask = 5'h00;
      tick(8);
      chk(o_batch_incomplete_flag, 1);
      sel_mask = 5'h03;
      tick(8);
      chk(o_work_invalid, 1);
      // Mid-run reset, then a one-piece batch in timer method
      {sel_mask, i_line_count_method, i_srst} = 9'h007;
      tick(5);
      i_srst = 1'b0;
      tick(3);
      fasten(3);
      chk({seen_ok, o_batch_ok}, 9'h100);
      wrap_up();
   end

   // Watchdog well past the few hundred cycles the tests need
   initial begin
      #400_000;
      fail_count++;
      wrap_up();
   end
endmodule : fastening_count_judge_tb
